// File: inc/jam_defines.svh
// Function
// [R1] centred stick holds still, deflection moves motor
// [R2] horizontal drives channels 1,3; vertical 2,4
// [R3] enabled pair moves together, each own axis
// [R4] three joystick modes decide deflection handling
// [R5] two taught targets per channel, chosen by direction
// [R6] up or left first target, else second
// [R7] one jog step per separate deflection
// [R8] forward/reverse jog sizes limited 1 to 2000
// [R9] velocity rate scales with deflection to maximum
// [R10] signed position count; go-to within +/-100000
// [R11] go-to steps selected channel until count matches
// [R12] zero command clears count without motion
// [R13] identify flashes title for limited time
// [R14] operator selects channel before go-to
// [R15] axis enable: single, pair, or none
// [R16] dead-band around centre counts as zero
// [R17] stop exactly at target, no overshoot
`ifndef JAM_DEFINES_SVH
`define JAM_DEFINES_SVH
`define JAM_AW 8
`define JAM_CLK_HZ 33'h0_017D_7840
`define JAM_CLK_KHZ 32'h0000_61A8
`define JAM_IDENT_MS 32'h0000_0BB8
`define JAM_BLINK_BIT 22
`define JAM_OFS_CTRL 8'h00
`define JAM_OFS_CMD 8'h04
`define JAM_OFS_GOTO 8'h08
`define JAM_OFS_RATE 8'h0C
`define JAM_OFS_DBAND 8'h10
`define JAM_OFS_STATUS 8'h14
`define JAM_PARAM_SEL 2'h1
`define JAM_POS_SEL 4'h8
`define JAM_CMD_GOTO 0
`define JAM_CMD_ZERO 1
`define JAM_CMD_IDENT 2
`define JAM_FLD_FWD 2'h0
`define JAM_FLD_REV 2'h1
`define JAM_FLD_TGT1 2'h2
`define JAM_FLD_TGT2 2'h3
`define JAM_MEM_DEPTH 16
`define JAM_JOG_MIN 32'sh0000_0001
`define JAM_JOG_MAX 32'sh0000_07D0
`define JAM_TGT_MIN 32'shFFFE_7960
`define JAM_TGT_MAX 32'sh0001_86A0
`define JAM_RATE_MIN 32'h0000_0001
`define JAM_RATE_MAX 32'h000F_4240
`define JAM_RATE_RST 32'h0000_03E8
`define JAM_DBAND_RST 8'h08
`define JAM_JOG_RST 32'h0000_0064
`define JAM_MAG_SHIFT 7
`define JAM_MODE_ILLEGAL 2'h3
`define JAM_RESP_OKAY 2'h0
`define JAM_RESP_SLVERR 2'h2
`endif

// File: inc/jam_pkg.sv
package jam_pkg;
   typedef enum logic [1:0] {JM_TARGET, JM_JOG, JM_VELOCITY} jam_joy_mode_t;
   typedef enum logic [1:0] {AX_SINGLE, AX_PAIR, AX_OFF} jam_axis_mode_t;
   typedef enum logic [1:0] {RD_IDLE, RD_MEM, RD_LOAD, RD_RESP} jam_rd_state_t;
   typedef struct packed {
      logic [1:0] sel;
      jam_axis_mode_t axis;
      jam_joy_mode_t joy;
   } jam_ctrl_t;
   typedef struct packed {
      logic go;
      logic neg;
   } jam_dir_t;
endpackage : jam_pkg

// File: rtl/jam_param_mem.sv
`timescale 1ns/1ps
`include "jam_defines.svh"
module jam_param_mem (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_we,
   input wire logic [3:0] i_waddr,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_raddr_a,
   output logic [31:0] o_rdata_a,
   input wire logic [3:0] i_raddr_b,
   output logic [31:0] o_rdata_b
);
   logic [31:0] mem_reg [`JAM_MEM_DEPTH];

   // reset loads usable jog sizes so a fresh device never jogs by garbage
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         for (int i = 0; i < `JAM_MEM_DEPTH; i++) begin
            mem_reg[i] <= (i[1] == 1'b0) ? `JAM_JOG_RST : 32'h0000_0000;
         end
      end else if (i_we) begin
         mem_reg[i_waddr] <= i_wdata;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_rdata_a <= 32'h0000_0000;
         o_rdata_b <= 32'h0000_0000;
      end else begin
         o_rdata_a <= mem_reg[i_raddr_a];
         o_rdata_b <= mem_reg[i_raddr_b];
      end
   end
endmodule : jam_param_mem

// File: rtl/jam_top.sv
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "jam_defines.svh"
module jam_top import jam_pkg::*; #(
   parameter logic [31:0] IDENT_CYCLES = `JAM_IDENT_MS * `JAM_CLK_KHZ
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic signed [7:0] i_joy_x,
   input wire logic signed [7:0] i_joy_y,
   input wire logic i_chan_sel_btn,
   input wire logic [`JAM_AW-1:0] i_s_awaddr,
   input wire logic i_s_awvalid,
   output logic o_s_awready,
   input wire logic [31:0] i_s_wdata,
   input wire logic [3:0] i_s_wstrb,
   input wire logic i_s_wvalid,
   output logic o_s_wready,
   output logic [1:0] o_s_bresp,
   output logic o_s_bvalid,
   input wire logic i_s_bready,
   input wire logic [`JAM_AW-1:0] i_s_araddr,
   input wire logic i_s_arvalid,
   output logic o_s_arready,
   output logic [31:0] o_s_rdata,
   output logic [1:0] o_s_rresp,
   output logic o_s_rvalid,
   input wire logic i_s_rready,
   output logic [3:0] o_step,
   output logic [3:0] o_dir,
   output logic [1:0] o_chan_sel,
   output logic o_title_flash
);
   jam_ctrl_t ctrl_reg;
   jam_ctrl_t ctrl_wr;
   logic [31:0] goto_reg;
   logic [31:0] rate_reg;
   logic [7:0] dband_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [1:0] bresp_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;
   logic [`JAM_AW-1:0] awaddr_reg;
   logic [`JAM_AW-1:0] araddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   jam_rd_state_t rd_state_reg;
   logic wr_fire;
   logic [31:0] wr_merged;
   logic [31:0] mem_rd_a;
   logic [31:0] mem_rd_b;
   logic mem_we;
   logic goto_req_reg;
   logic zero_req_reg;
   logic ident_req_reg;
   logic [31:0] ident_cnt_reg;
   logic title_flash_reg;
   logic btn_prev_reg;
   jam_dir_t xdir_reg;
   jam_dir_t ydir_reg;
   jam_dir_t xprev_reg;
   jam_dir_t yprev_reg;
   logic [31:0] mv_acc_reg;
   logic [31:0] vx_acc_reg;
   logic [31:0] vy_acc_reg;
   logic mv_tick_reg;
   logic vx_tick_reg;
   logic vy_tick_reg;
   logic [39:0] vx_prod;
   logic [39:0] vy_prod;
   logic [31:0] vx_inc;
   logic [31:0] vy_inc;
   logic [3:0] en;
   logic [3:0] ev;
   logic [3:0] ch_go;
   logic [3:0] ch_neg;
   logic [3:0] ch_vtick;
   logic [3:0] pend_reg;
   logic [3:0] pend_neg_reg;
   logic [3:0] active_reg;
   logic [31:0] pos_reg [4];
   logic [31:0] tgt_reg [4];
   logic [1:0] scan_reg;
   logic [1:0] scan_d_reg;
   logic neg_d_reg;
   logic jog_d_reg;
   logic [1:0] scan_fld;
   logic [3:0] step_reg;
   logic [3:0] dir_reg;

   function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge_strb

   function automatic logic in_range(input logic [31:0] v, input logic [31:0] lo,
                                     input logic [31:0] hi);
      return ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
   endfunction : in_range

   function automatic logic [7:0] joy_abs(input logic signed [7:0] v);
      return v[7] ? 8'(-v) : 8'(v);
   endfunction : joy_abs

   function automatic jam_dir_t joy_dir(input logic signed [7:0] v, input logic [7:0] db);
      jam_dir_t d;
      d.go = joy_abs(v) > db; // [R16] [R1]
      d.neg = v[7];
      return d;
   endfunction : joy_dir

   // accumulator wraps at the clock rate, giving exactly inc ticks per second
   function automatic logic [32:0] nco_step(input logic [31:0] acc, input logic [31:0] inc);
      logic [32:0] s;
      s = {1'b0, acc} + {1'b0, inc};
      if (s >= `JAM_CLK_HZ) begin
         return {1'b1, 32'(s - `JAM_CLK_HZ)};
      end
      return {1'b0, s[31:0]};
   endfunction : nco_step

   function automatic logic [3:0] en_mask(input jam_ctrl_t c);
      logic [3:0] m;
      unique case (c.axis) // [R15]
         AX_SINGLE: m = 4'h1 << c.sel;
         AX_PAIR: m = c.sel[1] ? 4'hC : 4'h3; // [R3]
         AX_OFF: m = 4'h0;
         default: m = 4'h0;
      endcase
      return m;
   endfunction : en_mask

   function automatic logic addr_ok(input logic [`JAM_AW-1:0] a);
      return (a[7:6] == `JAM_PARAM_SEL) || (a[7:4] == `JAM_POS_SEL) ||
             (a == `JAM_OFS_CTRL) || (a == `JAM_OFS_CMD) || (a == `JAM_OFS_GOTO) ||
             (a == `JAM_OFS_RATE) || (a == `JAM_OFS_DBAND) || (a == `JAM_OFS_STATUS);
   endfunction : addr_ok

   function automatic logic [31:0] reg_value(input logic [`JAM_AW-1:0] a);
      if (a[7:6] == `JAM_PARAM_SEL) begin
         return mem_rd_a;
      end
      if (a[7:4] == `JAM_POS_SEL) begin
         return pos_reg[a[3:2]];
      end
      case (a)
         `JAM_OFS_CTRL: return 32'(ctrl_reg);
         `JAM_OFS_GOTO: return goto_reg;
         `JAM_OFS_RATE: return rate_reg;
         `JAM_OFS_DBAND: return 32'(dband_reg);
         `JAM_OFS_STATUS: return 32'({ident_cnt_reg != 32'h0000_0000, pend_reg, active_reg});
         default: return 32'h0000_0000;
      endcase
   endfunction : reg_value

   jam_param_mem u_param_mem (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_we(mem_we),
      .i_waddr(awaddr_reg[5:2]),
      .i_wdata(wdata_reg),
      .i_raddr_a(araddr_reg[5:2]),
      .o_rdata_a(mem_rd_a),
      .i_raddr_b({scan_reg, scan_fld}),
      .o_rdata_b(mem_rd_b)
   );

   assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
   assign wr_merged = merge_strb(reg_value(awaddr_reg), wdata_reg, wstrb_reg);
   assign ctrl_wr = jam_ctrl_t'(wr_merged[$bits(jam_ctrl_t)-1:0]);
   // taught targets and jog sizes are whole words; byte strobes do not apply
   assign mem_we = wr_fire && (awaddr_reg[7:6] == `JAM_PARAM_SEL) &&
                   (awaddr_reg[3] ? in_range(wdata_reg, `JAM_TGT_MIN, `JAM_TGT_MAX)
                                  : in_range(wdata_reg, `JAM_JOG_MIN, `JAM_JOG_MAX)); // [R5] [R8]

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         bvalid_reg <= 1'b0;
         bresp_reg <= `JAM_RESP_OKAY;
         awaddr_reg <= '0;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
      end else begin
         if (awready_reg && i_s_awvalid) begin
            awaddr_reg <= i_s_awaddr;
            awready_reg <= 1'b0;
         end
         if (wready_reg && i_s_wvalid) begin
            wdata_reg <= i_s_wdata;
            wstrb_reg <= i_s_wstrb;
            wready_reg <= 1'b0;
         end
         if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= addr_ok(awaddr_reg) ? `JAM_RESP_OKAY : `JAM_RESP_SLVERR;
         end
         if (bvalid_reg && i_s_bready) begin
            bvalid_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         rd_state_reg <= RD_IDLE;
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= `JAM_RESP_OKAY;
         araddr_reg <= '0;
      end else begin
         unique case (rd_state_reg)
            RD_IDLE: begin
               if (i_s_arvalid) begin
                  araddr_reg <= i_s_araddr;
                  arready_reg <= 1'b0;
                  rd_state_reg <= RD_MEM;
               end
            end
            RD_MEM: rd_state_reg <= RD_LOAD;
            RD_LOAD: begin
               rvalid_reg <= 1'b1;
               rdata_reg <= reg_value(araddr_reg);
               rresp_reg <= addr_ok(araddr_reg) ? `JAM_RESP_OKAY : `JAM_RESP_SLVERR;
               rd_state_reg <= RD_RESP;
            end
            RD_RESP: begin
               if (i_s_rready) begin
                  rvalid_reg <= 1'b0;
                  arready_reg <= 1'b1;
                  rd_state_reg <= RD_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         goto_reg <= 32'h0000_0000;
         rate_reg <= `JAM_RATE_RST;
         dband_reg <= `JAM_DBAND_RST;
         goto_req_reg <= 1'b0;
         zero_req_reg <= 1'b0;
         ident_req_reg <= 1'b0;
      end else begin
         if (wr_fire && awaddr_reg == `JAM_OFS_GOTO &&
             in_range(wr_merged, `JAM_TGT_MIN, `JAM_TGT_MAX)) begin
            goto_reg <= wr_merged; // [R10]
         end
         if (wr_fire && awaddr_reg == `JAM_OFS_RATE &&
             wr_merged >= `JAM_RATE_MIN && wr_merged <= `JAM_RATE_MAX) begin
            rate_reg <= wr_merged; // [R9]
         end
         if (wr_fire && awaddr_reg == `JAM_OFS_DBAND) begin
            dband_reg <= wr_merged[7:0]; // [R16]
         end
         goto_req_reg <= wr_fire && awaddr_reg == `JAM_OFS_CMD && wr_merged[`JAM_CMD_GOTO];
         zero_req_reg <= wr_fire && awaddr_reg == `JAM_OFS_CMD && wr_merged[`JAM_CMD_ZERO];
         ident_req_reg <= wr_fire && awaddr_reg == `JAM_OFS_CMD && wr_merged[`JAM_CMD_IDENT];
      end
   end

   // a write in the same cycle as a button press takes precedence
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         ctrl_reg.sel <= '0;
         ctrl_reg.axis <= AX_SINGLE;
         ctrl_reg.joy <= JM_VELOCITY;
         btn_prev_reg <= 1'b0;
      end else begin
         btn_prev_reg <= i_chan_sel_btn;
         if (i_chan_sel_btn && !btn_prev_reg) begin
            ctrl_reg.sel <= (ctrl_reg.axis == AX_PAIR) ? {~ctrl_reg.sel[1], 1'b0}
                                                       : 2'(ctrl_reg.sel + 2'h1);
         end
         if (wr_fire && awaddr_reg == `JAM_OFS_CTRL) begin
            ctrl_reg.sel <= ctrl_wr.sel;
            if (ctrl_wr.joy != jam_joy_mode_t'(`JAM_MODE_ILLEGAL)) begin
               ctrl_reg.joy <= ctrl_wr.joy; // [R4]
            end
            if (ctrl_wr.axis != jam_axis_mode_t'(`JAM_MODE_ILLEGAL)) begin
               ctrl_reg.axis <= ctrl_wr.axis; // [R15]
            end
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         ident_cnt_reg <= 32'h0000_0000;
         title_flash_reg <= 1'b0;
      end else begin
         if (ident_req_reg) begin
            ident_cnt_reg <= IDENT_CYCLES; // [R13]
         end else if (ident_cnt_reg != 32'h0000_0000) begin
            ident_cnt_reg <= ident_cnt_reg - 32'h0000_0001;
         end
         title_flash_reg <= (ident_cnt_reg != 32'h0000_0000) && !ident_cnt_reg[`JAM_BLINK_BIT];
      end
   end

   // full deflection on the negative side lands exactly on the set maximum
   assign vx_prod = 40'(rate_reg) * 40'(joy_abs(i_joy_x));
   assign vy_prod = 40'(rate_reg) * 40'(joy_abs(i_joy_y));
   assign vx_inc = xdir_reg.go ? vx_prod[`JAM_MAG_SHIFT +: 32] : 32'h0000_0000; // [R9]
   assign vy_inc = ydir_reg.go ? vy_prod[`JAM_MAG_SHIFT +: 32] : 32'h0000_0000;

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         xdir_reg <= '0;
         ydir_reg <= '0;
         xprev_reg <= '0;
         yprev_reg <= '0;
         mv_acc_reg <= 32'h0000_0000;
         vx_acc_reg <= 32'h0000_0000;
         vy_acc_reg <= 32'h0000_0000;
         mv_tick_reg <= 1'b0;
         vx_tick_reg <= 1'b0;
         vy_tick_reg <= 1'b0;
      end else begin
         xdir_reg <= joy_dir(i_joy_x, dband_reg);
         ydir_reg <= joy_dir(i_joy_y, dband_reg);
         xprev_reg <= xdir_reg;
         yprev_reg <= ydir_reg;
         {mv_tick_reg, mv_acc_reg} <= nco_step(mv_acc_reg, rate_reg);
         {vx_tick_reg, vx_acc_reg} <= nco_step(vx_acc_reg, vx_inc);
         {vy_tick_reg, vy_acc_reg} <= nco_step(vy_acc_reg, vy_inc);
      end
   end

   always_comb begin
      en = en_mask(ctrl_reg);
      for (int c = 0; c < 4; c++) begin
         ch_go[c] = c[0] ? ydir_reg.go : xdir_reg.go; // [R2]
         ch_neg[c] = c[0] ? ydir_reg.neg : xdir_reg.neg;
         ch_vtick[c] = c[0] ? vy_tick_reg : vx_tick_reg;
         // a new deflection or a reversal, never a held one
         ev[c] = en[c] && ch_go[c] &&
                 (c[0] ? (ydir_reg != yprev_reg) : (xdir_reg != xprev_reg)); // [R7]
      end
      if (ctrl_reg.joy == JM_JOG) begin
         scan_fld = pend_neg_reg[scan_reg] ? `JAM_FLD_REV : `JAM_FLD_FWD; // [R8]
      end else begin
         scan_fld = (pend_neg_reg[scan_reg] ~^ scan_reg[0]) ? `JAM_FLD_TGT2
                                                            : `JAM_FLD_TGT1; // [R6]
      end
   end

   // starts are served by a round-robin scan so one memory port feeds all channels
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         scan_reg <= '0;
         scan_d_reg <= '0;
         neg_d_reg <= 1'b0;
         jog_d_reg <= 1'b0;
      end else begin
         scan_reg <= 2'(scan_reg + 2'h1);
         scan_d_reg <= scan_reg;
         neg_d_reg <= pend_neg_reg[scan_reg];
         jog_d_reg <= ctrl_reg.joy == JM_JOG;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         pend_reg <= 4'h0;
         pend_neg_reg <= 4'h0;
         active_reg <= 4'h0;
         step_reg <= 4'h0;
         dir_reg <= 4'h0;
         for (int c = 0; c < 4; c++) begin
            pos_reg[c] <= 32'h0000_0000;
            tgt_reg[c] <= 32'h0000_0000;
         end
      end else begin
         for (int c = 0; c < 4; c++) begin
            step_reg[c] <= 1'b0;
            if (active_reg[c]) begin
               if (pos_reg[c] == tgt_reg[c]) begin
                  active_reg[c] <= 1'b0; // [R17]
               end else if (mv_tick_reg) begin
                  step_reg[c] <= 1'b1;
                  dir_reg[c] <= $signed(tgt_reg[c]) > $signed(pos_reg[c]);
                  pos_reg[c] <= ($signed(tgt_reg[c]) > $signed(pos_reg[c])) ?
                                pos_reg[c] + 32'h0000_0001 : pos_reg[c] - 32'h0000_0001; // [R11]
               end
            end else if (ctrl_reg.joy == JM_VELOCITY && en[c] && ch_go[c] && ch_vtick[c]) begin
               step_reg[c] <= 1'b1; // [R1] [R3] [R9]
               dir_reg[c] <= !ch_neg[c];
               pos_reg[c] <= ch_neg[c] ? pos_reg[c] - 32'h0000_0001 : pos_reg[c] + 32'h0000_0001;
            end
            if (pend_reg[c] && scan_d_reg == 2'(c) && pend_neg_reg[c] == neg_d_reg) begin
               pend_reg[c] <= 1'b0;
               active_reg[c] <= 1'b1;
               if (jog_d_reg) begin
                  tgt_reg[c] <= neg_d_reg ? pos_reg[c] - mem_rd_b : pos_reg[c] + mem_rd_b; // [R7]
               end else begin
                  tgt_reg[c] <= mem_rd_b; // [R5]
               end
            end
            if (goto_req_reg && ctrl_reg.sel == 2'(c)) begin
               tgt_reg[c] <= goto_reg; // [R11] [R14]
               active_reg[c] <= 1'b1;
            end
            if (zero_req_reg && ctrl_reg.sel == 2'(c)) begin
               pos_reg[c] <= 32'h0000_0000; // [R12]
               active_reg[c] <= 1'b0;
               pend_reg[c] <= 1'b0;
            end
            // a fresh deflection is kept even when a start is consumed this cycle
            if (ev[c] && ctrl_reg.joy != JM_VELOCITY) begin
               pend_reg[c] <= 1'b1; // [R4]
               pend_neg_reg[c] <= ch_neg[c];
            end
         end
      end
   end

   assign o_s_awready = awready_reg;
   assign o_s_wready = wready_reg;
   assign o_s_bvalid = bvalid_reg;
   assign o_s_bresp = bresp_reg;
   assign o_s_arready = arready_reg;
   assign o_s_rvalid = rvalid_reg;
   assign o_s_rdata = rdata_reg;
   assign o_s_rresp = rresp_reg;
   assign o_step = step_reg;
   assign o_dir = dir_reg;
   assign o_chan_sel = ctrl_reg.sel;
   assign o_title_flash = title_flash_reg;
endmodule : jam_top

// File: tb/jam_top_sva.sv
`timescale 1ns/1ps
module jam_top_sva (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_s_awvalid,
   input wire logic o_s_awready,
   input wire logic i_s_wvalid,
   input wire logic o_s_wready,
   input wire logic [1:0] o_s_bresp,
   input wire logic o_s_bvalid,
   input wire logic i_s_bready,
   input wire logic i_s_arvalid,
   input wire logic o_s_arready,
   input wire logic [31:0] o_s_rdata,
   input wire logic o_s_rvalid,
   input wire logic i_s_rready,
   input wire logic [3:0] o_step,
   input wire logic [3:0] o_dir,
   input wire logic o_title_flash
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   property p_step_one;
      (o_step & $past(o_step)) == 4'h0;
   endproperty
   a_step_one: assert property (p_step_one)
      else $error("step pulse wider than one cycle");
   // dir may only move with a pulse, else the stage sees a stale direction
   property p_dir_step;
      ((o_dir ^ $past(o_dir)) & ~o_step) == 4'h0;
   endproperty
   a_dir_step: assert property (p_dir_step)
      else $error("direction changed without a step");
   property p_rst_quiet;
      disable iff (1'b0) i_rst |=> o_step == 4'h0 && !o_title_flash && !o_s_bvalid;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("outputs active after reset");
   property p_b_hold;
      o_s_bvalid && !i_s_bready |=> o_s_bvalid && $stable(o_s_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped early");
   property p_r_hold;
      o_s_rvalid && !i_s_rready |=> o_s_rvalid && $stable(o_s_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped early");
   property p_b_lat;
      o_s_awready && i_s_awvalid && o_s_wready && i_s_wvalid |-> ##[1:2] o_s_bvalid;
   endproperty
   a_b_lat: assert property (p_b_lat)
      else $error("write response late");
   property p_r_lat;
      o_s_arready && i_s_arvalid |-> ##[1:3] o_s_rvalid;
   endproperty
   a_r_lat: assert property (p_r_lat)
      else $error("read response late");
   property p_busy;
      o_s_bvalid |-> !o_s_awready && !o_s_wready;
   endproperty
   a_busy: assert property (p_busy)
      else $error("write accepted while response pending");
endmodule : jam_top_sva
bind jam_top jam_top_sva u_jam_top_sva (.*);

// File: tb/jam_motor_model.sv
`timescale 1ns/1ps
module jam_motor_model (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic [3:0] i_step,
   input wire logic [3:0] i_dir,
   output logic [3:0][31:0] o_pos
);
   // stage keeps its place across a zero command, only pulses move it
   always_ff @(posedge i_sys_clk) begin
      for (int c = 0; c < 4; c++) begin
         if (i_rst) begin
            o_pos[c] <= 32'h0;
         end else if (i_step[c]) begin
            o_pos[c] <= i_dir[c] ? o_pos[c] + 32'h1 : o_pos[c] - 32'h1;
         end
      end
   end
endmodule : jam_motor_model

// File: tb/tb_joystick_axis_motion_control.sv
`timescale 1ns/1ps
module tb_joystick_axis_motion_control;
   logic i_sys_clk = 1'b0, i_rst = 1'b1, i_chan_sel_btn = 1'b0;
   logic signed [7:0] i_joy_x = 8'h00, i_joy_y = 8'h00;
   logic [7:0] i_s_awaddr = 8'h00, i_s_araddr = 8'h00;
   logic [31:0] i_s_wdata = 32'h0, o_s_rdata, g, k1, k2, t1, t2, u1, d;
   logic [3:0] i_s_wstrb = 4'hF, o_step, o_dir;
   logic i_s_awvalid = 0, i_s_wvalid = 0, i_s_bready = 0, i_s_arvalid = 0, i_s_rready = 0;
   logic o_s_awready, o_s_wready, o_s_bvalid, o_s_arready, o_s_rvalid, o_title_flash;
   logic [1:0] o_s_bresp, o_s_rresp, o_chan_sel;
   logic [3:0][31:0] pos;
   int n_mismatch = 0, n_tests = 0, n1, n2;
   jam_top #(.IDENT_CYCLES(32'h0000_00C8)) u_jam_top (.*);
   jam_motor_model u_jam_motor_model (.i_sys_clk, .i_rst, .i_step(o_step), .i_dir(o_dir),
      .o_pos(pos));
   initial forever #20 i_sys_clk = ~i_sys_clk;
   task automatic conclude;
      $display("mismatches %0d tests %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = 2'h0);
      logic ta, tw;
      ta = 0;
      tw = 0;
      i_s_awaddr <= a;
      i_s_wdata <= v;
      i_s_awvalid <= 1;
      i_s_wvalid <= 1;
      while (!(ta && tw)) begin
         @(posedge i_sys_clk);
         ta = ta | o_s_awready;
         tw = tw | o_s_wready;
         if (ta) i_s_awvalid <= 0;
         if (tw) i_s_wvalid <= 0;
      end
      do @(posedge i_sys_clk); while (!o_s_bvalid);
      // late bready keeps the response waiting a cycle
      i_s_bready <= 1;
      @(posedge i_sys_clk);
      i_s_bready <= 0;
      chk("bresp", o_s_bresp, er);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
      i_s_araddr <= a;
      i_s_arvalid <= 1;
      do begin
         @(posedge i_sys_clk);
         if (o_s_arready) i_s_arvalid <= 0;
      end while (!o_s_rvalid);
      i_s_rready <= 1;
      @(posedge i_sys_clk);
      i_s_rready <= 0;
      chk("rdata", o_s_rdata, e);
      chk("rresp", o_s_rresp, er);
   endtask : rd
   // quiet span beats the slowest pulse spacing, so a move is surely over
   task automatic settle;
      int q;
      q = 0;
      while (q < 120) begin
         @(posedge i_sys_clk);
         q = (o_step != 4'h0) ? 0 : q + 1;
      end
   endtask : settle
   task automatic joy(input logic [7:0] x, input logic [7:0] y);
      i_joy_x <= x;
      i_joy_y <= y;
      settle();
      i_joy_x <= 8'h00;
      i_joy_y <= 8'h00;
      settle();
   endtask : joy
   task automatic cnt(input int n, output int k);
      k = 0;
      repeat (n) begin
         @(posedge i_sys_clk);
         k = k + int'(o_step[0]);
      end
   endtask : cnt
   function automatic logic near(input int k, input int rate, input int dfl, input int n);
      int e;
      e = int'(longint'(rate) * dfl * n / 128 / 25000000);
      return k >= e - 2 && k <= e + 2;
   endfunction : near
   initial begin
      #(60000 * 40);
      n_mismatch++;
      conclude();
   end
   initial begin
      n1 = $urandom(45);
      repeat (2) @(posedge i_sys_clk);
      i_rst <= 0;
      rd(8'h00, 32'h2);
      rd(8'h0C, 32'h3E8);
      rd(8'h10, 32'h8);
      rd(8'h40, 32'h64);
      rd(8'h3C, 32'h0, 2'h2);
      wr(8'h3C, 32'h5, 2'h2);
      wr(8'h0C, 32'h000F_4241);
      rd(8'h0C, 32'h3E8);
      wr(8'h0C, 32'h000F_4240);
      rd(8'h0C, 32'h000F_4240);
      for (int i = 0; i < 3; i++) begin
         g = $urandom_range(40) - 20;
         wr(8'h08, g);
         wr(8'h04, 32'h1);
         settle();
         chk("pos", pos[0], g);
         rd(8'h80, g);
      end
      wr(8'h08, 32'h0001_86A1);
      rd(8'h08, g);
      wr(8'h08, 32'hFFFE_7960);
      rd(8'h08, 32'hFFFE_7960);
      wr(8'h04, 32'h2);
      settle();
      chk("pos", pos[0], g);
      rd(8'h80, 32'h0);
      wr(8'h00, 32'h1);
      k1 = $urandom_range(9, 1);
      k2 = $urandom_range(9, 1);
      wr(8'h40, k1);
      wr(8'h44, k2);
      wr(8'h40, 32'h0);
      rd(8'h40, k1);
      wr(8'h44, 32'h7D1);
      rd(8'h44, k2);
      wr(8'h50, 32'h7D0);
      rd(8'h50, 32'h7D0);
      joy(8'h08, 8'h00);
      chk("pos", pos[0], g);
      joy(8'h3C, 8'h00);
      chk("pos", pos[0], g + k1);
      joy(8'hC4, 8'h00);
      chk("pos", pos[0], g + k1 - k2);
      wr(8'h00, 32'h0);
      t1 = 0 - $urandom_range(20, 1);
      t2 = $urandom_range(20, 1);
      wr(8'h48, t1);
      wr(8'h4C, t2);
      joy(8'hC4, 8'h00);
      chk("pos", pos[0], g + t1);
      joy(8'h3C, 8'h00);
      chk("pos", pos[0], g + t2);
      wr(8'h00, 32'h4);
      u1 = $urandom_range(20, 1);
      wr(8'h58, u1);
      wr(8'h5C, 32'hFFFF_FFFD);
      joy(8'hC4, 8'h3C);
      chk("pos", pos[0], g + t1);
      chk("pos", pos[1], u1);
      joy(8'h00, 8'hC4);
      chk("pos", pos[1], 32'hFFFF_FFFD);
      wr(8'h00, 32'h2);
      i_chan_sel_btn <= 1;
      repeat (3) @(posedge i_sys_clk);
      i_chan_sel_btn <= 0;
      repeat (3) @(posedge i_sys_clk);
      chk("sel", o_chan_sel, 32'h1);
      wr(8'h08, 32'h5);
      wr(8'h04, 32'h1);
      settle();
      chk("pos", pos[1], 32'h5);
      chk("pos", pos[0], g + t1);
      wr(8'h00, 32'h2);
      i_joy_x <= 8'h7F;
      cnt(2500, n1);
      i_joy_x <= 8'h40;
      cnt(2500, n2);
      chk("vel", near(n1, 1000000, 127, 2500), 32'h1);
      chk("vel", near(n2, 1000000, 64, 2500), 32'h1);
      i_joy_x <= 8'h00;
      i_joy_y <= 8'h7F;
      settle();
      cnt(500, n1);
      chk("vel", 32'(n1), 32'h0);
      i_joy_y <= 8'h00;
      wr(8'h00, 32'hA);
      i_joy_x <= 8'h80;
      cnt(500, n1);
      chk("vel", 32'(n1), 32'h0);
      i_joy_x <= 8'h00;
      wr(8'h04, 32'h4);
      repeat (4) @(posedge i_sys_clk);
      chk("flash", o_title_flash, 32'h1);
      repeat (250) @(posedge i_sys_clk);
      chk("flash", o_title_flash, 32'h0);
      conclude();
   end
endmodule : tb_joystick_axis_motion_control
